/* File: timer8_defs.svh */
// Constants of the 8-bit timer mode and clock control block.
// Included by the package users; holds definitions only.
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH

// APB byte offsets
`define TMR_OFF_CTRL_A 8'h00
`define TMR_OFF_CTRL_B 8'h04
`define TMR_OFF_COUNT 8'h08
`define TMR_OFF_CMP_A 8'h0C
`define TMR_OFF_CMP_B 8'h10
`define TMR_OFF_FLAGS 8'h14

// Field positions
`define TMR_CA_COM_A_HI 7
`define TMR_CA_COM_A_LO 6
`define TMR_CA_COM_B_HI 5
`define TMR_CA_COM_B_LO 4
`define TMR_CB_FORCE_A 7
`define TMR_CB_FORCE_B 6
`define TMR_CB_WGM_HIGH 3
`define TMR_FL_OVERFLOW 0
`define TMR_FL_MATCH_A 1
`define TMR_FL_MATCH_B 2

// Reset values
`define TMR_RST_BYTE 8'h00
`define TMR_RST_FLAGS 3'h0

// Counter landmarks
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00

// Waveform modes
`define TMR_WM_NORMAL 3'h0
`define TMR_WM_PC_FF 3'h1
`define TMR_WM_CTC 3'h2
`define TMR_WM_FAST_FF 3'h3
`define TMR_WM_PC_CMP 3'h5
`define TMR_WM_FAST_CMP 3'h7

// Clock select codes and prescale masks
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7
`define TMR_PSC_W 10
`define TMR_MASK_DIV8 10'h007
`define TMR_MASK_DIV64 10'h03F
`define TMR_MASK_DIV256 10'h0FF
`define TMR_MASK_DIV1024 10'h3FF

`endif

/* File: timer8_pkg.sv */
// Types shared by the 8-bit timer control files.
// Constants live in timer8_defs.svh.
package timer8_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] wave_mode_t;
    typedef logic [1:0] out_mode_t;
    typedef logic [2:0] clk_sel_t;
endpackage

/* File: timer8_clock_select.sv */
// Timer clock selection: free prescaler plus external count input edge detect.
// Assumes the external input is asynchronous to i_core_clk.
`timescale 1ns/10ps
`default_nettype none
`include "timer8_defs.svh"

module timer8_clock_select (
    input wire logic i_core_clk,                        // I/O clock
    input wire logic i_rst_n,                           // Async reset, active low
    input wire timer8_pkg::clk_sel_t i_clock_source_select, // Clock source field
    input wire logic i_external_count_input,            // Raw count pin level
    output logic o_count_tick                           // One-cycle count enable
);
    import timer8_pkg::*;

    logic [`TMR_PSC_W-1:0] psc_q;
    logic sync1_q;
    logic sync2_q;
    logic ext_prev_q;
    logic ext_rise;
    logic ext_fall;
    logic div_tick;

    // Prescaler runs free so a new selection never restarts the phase
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            psc_q <= '0;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            psc_q <= psc_q + 1'b1;
            sync1_q <= i_external_count_input;
            sync2_q <= sync1_q;
            ext_prev_q <= sync2_q;
        end
    end

    // Only the second stage feeds the edge detector
    assign ext_rise = sync2_q & ~ext_prev_q;
    assign ext_fall = ~sync2_q & ext_prev_q;

    // Pin level is taken regardless of its port direction
    always_comb begin
        case (i_clock_source_select)
            `TMR_CS_STOP: div_tick = 1'b0;
            `TMR_CS_DIV1: div_tick = 1'b1;
            `TMR_CS_DIV8: div_tick = &(psc_q | ~`TMR_MASK_DIV8);
            `TMR_CS_DIV64: div_tick = &(psc_q | ~`TMR_MASK_DIV64);
            `TMR_CS_DIV256: div_tick = &(psc_q | ~`TMR_MASK_DIV256);
            `TMR_CS_DIV1024: div_tick = &(psc_q | ~`TMR_MASK_DIV1024);
            `TMR_CS_EXT_FALL: div_tick = ext_fall;
            `TMR_CS_EXT_RISE: div_tick = ext_rise;
            default: div_tick = 1'b0;
        endcase
    end

    assign o_count_tick = div_tick;
endmodule
`default_nettype wire

/* File: timer8_mode_and_clock_control.sv */
// 8-bit timer/counter with two compare channels, waveform modes and clock select.
// Assumes an APB master on i_core_clk; port direction logic sits outside.
// Function
// - Fast PWM, B field: 00 port, 01 reserved, 10 clear match/set TOP, 11 reverse.
// - PWM, compare B equal TOP with upper mode bit: skip match, still act at TOP.
// - Phase-correct, B field: 10 clear up-match/set down-match, 11 reverse.
// - Control A bits 3:2 and control B bits 5:4 read as zero.
// - Waveform mode is control B bit 3 over control A bits 1:0; 4, 6 reserved.
// - Modes 0 and 2: TOP 0xFF or compare A, immediate update, overflow at MAX.
// - PWM modes buffer compares to TOP; overflow at BOTTOM, MAX or TOP per mode.
// - MAX is 0xFF and BOTTOM is 0x00.
// - Force bit in non-PWM mode applies the channel action using current field.
// - Force sets no compare flag and never clears the counter.
// - Force bits are write-only strobes reading zero.
// - Clock select 001 undivided, 010..101 divide by 8, 64, 256, 1024.
// - Clock select 000 stops the counter.
// - Clock select 110 counts falling external edges, 111 rising edges.
// - External edges count even when that pin is an output.
// - Non-PWM, B field: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Nonzero output field overrides the port; direction must still be output.
`timescale 1ns/10ps
`default_nettype none
`include "timer8_defs.svh"

module timer8_mode_and_clock_control (
    input wire logic i_core_clk,              // I/O clock, 125 MHz
    input wire logic i_rst_n,                 // Async reset, active low
    input wire logic i_psel,                  // APB select
    input wire logic i_penable,               // APB access phase
    input wire logic i_pwrite,                // APB write
    input wire logic [7:0] i_paddr,           // APB byte address
    input wire logic [31:0] i_pwdata,         // APB write data
    output logic [31:0] o_prdata,             // APB read data
    output logic o_pready,                    // APB ready
    output logic o_pslverr,                   // APB error on unmapped address
    input wire logic i_external_count_input,  // External count pin level
    output logic o_compare_a_output_pin,      // Channel A waveform
    output logic o_compare_b_output_pin,      // Channel B waveform
    output logic o_compare_a_override,        // Channel A owns its pin
    output logic o_compare_b_override,        // Channel B owns its pin
    output timer8_pkg::byte_t o_counter_value,// Current count
    output logic o_overflow_flag,             // Sticky overflow flag
    output logic o_compare_a_flag,            // Sticky match A flag
    output logic o_compare_b_flag             // Sticky match B flag
);
    import timer8_pkg::*;

    // Action codes equal the non-PWM output field codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    out_mode_t compare_output_mode_q [2];
    logic [1:0] waveform_mode_low_bits_q;
    logic waveform_mode_high_bit_q;
    clk_sel_t clock_source_select_q;
    byte_t counter_value_q;
    byte_t cmp_buf_q [2];
    byte_t cmp_act_q [2];
    logic [2:0] flags_q;
    logic count_up_q;
    logic block_q;
    logic [1:0] pin_q;
    logic [31:0] prdata_q;

    logic tick;
    wave_mode_t waveform_mode_select;
    logic is_pwm;
    logic is_fast;
    logic is_phase;
    byte_t top;
    logic at_top;
    logic top_tick;
    logic ovf_set;
    logic [1:0] match;
    logic [1:0] force_hit;
    logic [1:0] act [2];
    byte_t cnt_d;
    logic up_d;

    logic wr_en;
    logic rd_setup;
    logic sel_ctrl_a;
    logic sel_ctrl_b;
    logic sel_count;
    logic sel_cmp_a;
    logic sel_cmp_b;
    logic sel_flags;
    logic mapped;
    logic [31:0] rd_mux;

    timer8_clock_select u_clock_select (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_clock_source_select(clock_source_select_q),
        .i_external_count_input(i_external_count_input),
        .o_count_tick(tick)
    );

    // Bus decode: one-cycle access phase, pready follows penable
    assign sel_ctrl_a = (i_paddr == `TMR_OFF_CTRL_A);
    assign sel_ctrl_b = (i_paddr == `TMR_OFF_CTRL_B);
    assign sel_count = (i_paddr == `TMR_OFF_COUNT);
    assign sel_cmp_a = (i_paddr == `TMR_OFF_CMP_A);
    assign sel_cmp_b = (i_paddr == `TMR_OFF_CMP_B);
    assign sel_flags = (i_paddr == `TMR_OFF_FLAGS);
    assign mapped = sel_ctrl_a | sel_ctrl_b | sel_count | sel_cmp_a | sel_cmp_b | sel_flags;
    assign wr_en = i_psel & i_penable & i_pwrite & mapped;
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign o_pready = i_psel & i_penable;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    // Reserved and strobe bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl_a) begin
            rd_mux[7:0] = {compare_output_mode_q[0], compare_output_mode_q[1], 2'h0,
                waveform_mode_low_bits_q};
        end
        if (sel_ctrl_b) begin
            rd_mux[7:0] = {4'h0, waveform_mode_high_bit_q, clock_source_select_q};
        end
        if (sel_count) begin
            rd_mux[7:0] = counter_value_q;
        end
        if (sel_cmp_a) begin
            rd_mux[7:0] = cmp_buf_q[0];
        end
        if (sel_cmp_b) begin
            rd_mux[7:0] = cmp_buf_q[1];
        end
        if (sel_flags) begin
            rd_mux[2:0] = flags_q;
        end
    end

    // Mode decode: high bit from control B above control A low bits
    assign waveform_mode_select = {waveform_mode_high_bit_q, waveform_mode_low_bits_q};
    assign is_fast = (waveform_mode_select == `TMR_WM_FAST_FF) ||
        (waveform_mode_select == `TMR_WM_FAST_CMP);
    assign is_phase = (waveform_mode_select == `TMR_WM_PC_FF) ||
        (waveform_mode_select == `TMR_WM_PC_CMP);
    assign is_pwm = is_fast | is_phase;

    // TOP from compare A in modes 2, 5, 7, else MAX
    assign top = (waveform_mode_select == `TMR_WM_CTC ||
        waveform_mode_select == `TMR_WM_PC_CMP ||
        waveform_mode_select == `TMR_WM_FAST_CMP) ? cmp_act_q[0] : `TMR_MAX;
    assign at_top = (counter_value_q == top);
    assign top_tick = tick & at_top;

    // Overflow point per mode
    always_comb begin
        case (waveform_mode_select)
            `TMR_WM_PC_FF, `TMR_WM_PC_CMP:
                ovf_set = tick & ~count_up_q & (counter_value_q == `TMR_BOTTOM);
            `TMR_WM_FAST_CMP: ovf_set = top_tick;
            default: ovf_set = tick & (counter_value_q == `TMR_MAX);
        endcase
    end

    // Counting sequence; reserved modes count like normal with outputs idle
    always_comb begin
        cnt_d = counter_value_q;
        up_d = count_up_q;
        if (wr_en && sel_count) begin
            cnt_d = i_pwdata[7:0];
        end else if (tick) begin
            if (is_phase) begin
                if (count_up_q && at_top) begin
                    up_d = 1'b0;
                    cnt_d = counter_value_q - 8'h01;
                end else if (!count_up_q && counter_value_q == `TMR_BOTTOM) begin
                    up_d = 1'b1;
                    cnt_d = counter_value_q + 8'h01;
                end else begin
                    cnt_d = count_up_q ? counter_value_q + 8'h01 : counter_value_q - 8'h01;
                end
            end else begin
                up_d = 1'b1;
                // Only a real match clears in CLEAR_ON_MATCH_MODE, never a force strobe
                if ((is_fast || waveform_mode_select == `TMR_WM_CTC) && at_top) begin
                    cnt_d = `TMR_BOTTOM;
                end else begin
                    cnt_d = counter_value_q + 8'h01;
                end
            end
        end
    end

    // Force strobes act only outside PWM; software keeps them zero there
    assign force_hit[0] = wr_en & sel_ctrl_b & i_pwdata[`TMR_CB_FORCE_A] & ~is_pwm;
    assign force_hit[1] = wr_en & sel_ctrl_b & i_pwdata[`TMR_CB_FORCE_B] & ~is_pwm;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic special;
            logic [1:0] com;
            assign com = compare_output_mode_q[ch];
            // A counter write suppresses the match on the next timer tick
            assign match[ch] = tick & ~block_q & (counter_value_q == cmp_act_q[ch]);
            // In PWM modes a match at TOP is ignored when the upper field bit is set
            assign special = com[1] & (cmp_act_q[ch] == top);

            always_comb begin
                act[ch] = ACT_NONE;
                if (!is_pwm) begin
                    if (waveform_mode_select[2] == 1'b0 && (match[ch] || force_hit[ch])) begin
                        act[ch] = com;
                    end
                end else if (com == 2'h1) begin
                    // Toggle in PWM exists on channel A only, with the high mode bit
                    if (ch == 0 && waveform_mode_high_bit_q && match[ch]) begin
                        act[ch] = ACT_TOGGLE;
                    end
                end else if (com[1]) begin
                    if (is_fast) begin
                        if (top_tick) begin
                            act[ch] = com[0] ? ACT_CLEAR : ACT_SET;
                        end else if (match[ch] && !special) begin
                            act[ch] = com;
                        end
                    end else begin
                        if (special && top_tick) begin
                            act[ch] = com[0] ? ACT_CLEAR : ACT_SET;
                        end else if (match[ch] && !special) begin
                            act[ch] = count_up_q ? com :
                                (com[0] ? ACT_CLEAR : ACT_SET);
                        end
                    end
                end
            end

            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pin_q[ch] <= 1'b0;
                end else begin
                    case (act[ch])
                        ACT_TOGGLE: pin_q[ch] <= ~pin_q[ch];
                        ACT_CLEAR: pin_q[ch] <= 1'b0;
                        ACT_SET: pin_q[ch] <= 1'b1;
                        default: pin_q[ch] <= pin_q[ch];
                    endcase
                end
            end

            // Buffered compare: immediate outside PWM, at TOP in PWM
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cmp_act_q[ch] <= `TMR_RST_BYTE;
                end else if (!is_pwm || top_tick) begin
                    cmp_act_q[ch] <= cmp_buf_q[ch];
                end
            end
        end
    endgenerate

    // Control, compare buffers, counter and flags
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            compare_output_mode_q[0] <= 2'h0;
            compare_output_mode_q[1] <= 2'h0;
            waveform_mode_low_bits_q <= 2'h0;
            waveform_mode_high_bit_q <= 1'b0;
            clock_source_select_q <= `TMR_CS_STOP;
            cmp_buf_q[0] <= `TMR_RST_BYTE;
            cmp_buf_q[1] <= `TMR_RST_BYTE;
        end else if (wr_en) begin
            if (sel_ctrl_a) begin
                compare_output_mode_q[0] <= i_pwdata[`TMR_CA_COM_A_HI:`TMR_CA_COM_A_LO];
                compare_output_mode_q[1] <= i_pwdata[`TMR_CA_COM_B_HI:`TMR_CA_COM_B_LO];
                waveform_mode_low_bits_q <= i_pwdata[1:0];
            end
            if (sel_ctrl_b) begin
                waveform_mode_high_bit_q <= i_pwdata[`TMR_CB_WGM_HIGH];
                clock_source_select_q <= i_pwdata[2:0];
            end
            if (sel_cmp_a) begin
                cmp_buf_q[0] <= i_pwdata[7:0];
            end
            if (sel_cmp_b) begin
                cmp_buf_q[1] <= i_pwdata[7:0];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            counter_value_q <= `TMR_RST_BYTE;
            count_up_q <= 1'b1;
            block_q <= 1'b0;
            flags_q <= `TMR_RST_FLAGS;
            prdata_q <= 32'h0000_0000;
        end else begin
            counter_value_q <= cnt_d;
            count_up_q <= up_d;
            block_q <= (wr_en & sel_count) | (block_q & ~tick);
            // Hardware set wins over a write-one clear; force never sets
            flags_q <= (flags_q & ~((wr_en & sel_flags) ? i_pwdata[2:0] : 3'h0)) |
                {match[1], match[0], ovf_set};
            if (rd_setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_compare_a_output_pin = pin_q[0];
    assign o_compare_b_output_pin = pin_q[1];
    // Port direction outside must still be output for the pin to drive
    assign o_compare_a_override = |compare_output_mode_q[0];
    assign o_compare_b_override = |compare_output_mode_q[1];
    assign o_counter_value = counter_value_q;
    assign o_overflow_flag = flags_q[`TMR_FL_OVERFLOW];
    assign o_compare_a_flag = flags_q[`TMR_FL_MATCH_A];
    assign o_compare_b_flag = flags_q[`TMR_FL_MATCH_B];
endmodule
`default_nettype wire

/* File: timer8_monitor.sv */
// Checker for the timer control block: register view, clock select and channel B actions.
// Sees only the top module's ports and tracks the control fields from APB writes.
`timescale 1ns/10ps
`default_nettype none
`include "timer8_defs.svh"

module timer8_monitor (
    input wire logic i_core_clk,                 // I/O clock
    input wire logic i_rst_n,                    // Async reset, active low
    input wire logic i_psel,                     // APB select
    input wire logic i_penable,                  // APB access phase
    input wire logic i_pwrite,                   // APB write
    input wire logic [7:0] i_paddr,              // APB address
    input wire logic [31:0] i_pwdata,            // APB write data
    input wire logic [31:0] o_prdata,            // APB read data
    input wire logic o_compare_b_output_pin,     // Channel B waveform
    input wire logic o_compare_a_override,       // Channel A owns pin
    input wire logic o_compare_b_override,       // Channel B owns pin
    input wire timer8_pkg::byte_t o_counter_value, // Count
    input wire logic o_overflow_flag,            // Overflow flag
    input wire logic o_compare_a_flag,           // Match A flag
    input wire logic o_compare_b_flag            // Match B flag
);
    import timer8_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    wire acc = i_psel && i_penable;
    wire wr_any = acc && i_pwrite;
    wire wr_a = wr_any && i_paddr == `TMR_OFF_CTRL_A;
    wire wr_b = wr_any && i_paddr == `TMR_OFF_CTRL_B;
    wire rd_a = acc && !i_pwrite && i_paddr == `TMR_OFF_CTRL_A;
    wire rd_b = acc && !i_pwrite && i_paddr == `TMR_OFF_CTRL_B;
    logic [1:0] com_a_q, com_b_q, wl_q;
    logic wh_q;
    clk_sel_t cs_q;
    wire [2:0] mode = {wh_q, wl_q};

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {com_a_q, com_b_q, wl_q} <= 6'h00;
            {wh_q, cs_q} <= 4'h0;
        end else begin
            if (wr_a) {com_a_q, com_b_q, wl_q} <= {i_pwdata[7:4], i_pwdata[1:0]};
            if (wr_b) {wh_q, cs_q} <= i_pwdata[3:0];
        end
    end

    a_ctrl_a_reserved: assert property (rd_a |-> o_prdata[3:2] == 2'b00)
        else $error("control A reserved bits read nonzero");
    a_ctrl_b_zeros: assert property (rd_b |-> o_prdata[7:4] == 4'h0)
        else $error("control B force or reserved bits read nonzero");
    a_stop_holds: assert property ((cs_q == `TMR_CS_STOP && !wr_any) [*4]
        |=> $stable(o_counter_value)) else $error("counter moved while stopped");
    a_ovf_at_max: assert property (mode == `TMR_WM_NORMAL && cs_q == `TMR_CS_DIV1
        && $past(cs_q) == `TMR_CS_DIV1 && o_counter_value == `TMR_MAX && !wr_any
        |=> o_overflow_flag) else $error("no overflow after MAX in normal mode");
    a_fast_top_act: assert property (mode == `TMR_WM_FAST_FF && com_b_q[1]
        && cs_q == `TMR_CS_DIV1 && $past(cs_q) == `TMR_CS_DIV1 && !wr_any
        && o_counter_value == `TMR_MAX |=> o_compare_b_output_pin == !com_b_q[0])
        else $error("fast PWM TOP action wrong on channel B");
    a_override_map: assert property (o_compare_b_override == (com_b_q != 2'b00)
        && o_compare_a_override == (com_a_q != 2'b00)) else $error("override mismatch");
    a_force_no_flag: assert property (wr_b && i_pwdata[7:6] != 2'b00
        && i_pwdata[2:0] == `TMR_CS_STOP && cs_q == `TMR_CS_STOP && !o_compare_a_flag
        && !o_compare_b_flag |=> !o_compare_a_flag && !o_compare_b_flag
        && $stable(o_counter_value)) else $error("force strobe set a flag or moved count");
    a_force_set_b: assert property (wr_b && i_pwdata[6] && !wh_q && !wl_q[0]
        && com_b_q == 2'b11 |-> ##[1:2] o_compare_b_output_pin)
        else $error("force B did not set the pin");
    a_pwm_force_inert: assert property (wr_b && i_pwdata[6] && wl_q[0]
        && cs_q == `TMR_CS_STOP && i_pwdata[2:0] == `TMR_CS_STOP
        |=> $stable(o_compare_b_output_pin)) else $error("force acted in PWM mode");

    c_force: cover property (wr_b && i_pwdata[6]);
    c_phase_top: cover property (mode == `TMR_WM_PC_FF && o_counter_value == `TMR_MAX);
    c_overflow: cover property (o_overflow_flag);
endmodule

bind timer8_mode_and_clock_control timer8_monitor mon (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_compare_b_output_pin(o_compare_b_output_pin),
    .o_compare_a_override(o_compare_a_override), .o_compare_b_override(o_compare_b_override),
    .o_counter_value(o_counter_value), .o_overflow_flag(o_overflow_flag),
    .o_compare_a_flag(o_compare_a_flag), .o_compare_b_flag(o_compare_b_flag));
`default_nettype wire

/* File: timer8_mode_and_clock_control_bench.sv */
// Self-checking bench for the timer control block.
// Drives APB and the count pin; the checker is bound from its own file.
`timescale 1ns/10ps
`default_nettype none
`include "timer8_defs.svh"

module timer8_mode_and_clock_control_bench;
    import timer8_pkg::*;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_external_count_input = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata;
    logic o_pready, o_pslverr, pin_a, pin_b, ov_a, ov_b, fl_ov, fl_a, fl_b, eb;
    byte_t cnt, s0;
    int err_count = 0, n_compared = 0, r, divs[6] = '{4, 1, 8, 64, 256, 1024};
    logic [32:0] expq[$];

    timer8_mode_and_clock_control dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_external_count_input(i_external_count_input), .o_compare_a_output_pin(pin_a),
        .o_compare_b_output_pin(pin_b), .o_compare_a_override(ov_a),
        .o_compare_b_override(ov_b), .o_counter_value(cnt), .o_overflow_flag(fl_ov),
        .o_compare_a_flag(fl_a), .o_compare_b_flag(fl_b));

    initial begin
        forever #4 i_core_clk = ~i_core_clk;
    end

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic fail_out();
        err_count++;
        wrap_up();
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Setup cycle, then access held until pready is seen high at an edge
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_psel <= 1'b1;
        i_pwrite <= wr_en;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        if (n >= 16) fail_out();
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input byte_t d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_cnt(input byte_t v);
        int n;
        n = 0;
        while (cnt !== v && n < 3000) begin
            @(posedge i_core_clk);
            n++;
        end
        if (n >= 3000) fail_out();
    endtask

    // Read results are paired with the oldest noted expectation
    always @(posedge i_core_clk) begin
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
            check({o_pslverr, o_prdata}, expq.pop_front());
        end
    end

    initial begin
        repeat (90000) @(posedge i_core_clk);
        fail_out();
    end

    initial begin
        r = $urandom(32'h90E715B1);
        repeat (10) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        rd(`TMR_OFF_CTRL_A, 33'h0);
        rd(`TMR_OFF_CTRL_B, 33'h0);
        wr(`TMR_OFF_CTRL_A, 8'hFF);
        rd(`TMR_OFF_CTRL_A, 33'hF3);
        wr(`TMR_OFF_CTRL_B, 8'hF0);
        rd(`TMR_OFF_CTRL_B, 33'h00);
        wr(`TMR_OFF_CTRL_B, 8'h08);
        rd(`TMR_OFF_CTRL_B, 33'h08);
        rd(8'h18, 33'h100000000);
        // Force strobes with the counter stopped: toggle A, set B, then clear B
        wr(`TMR_OFF_CTRL_B, 8'h00);
        wr(`TMR_OFF_CTRL_A, 8'h70);
        wr(`TMR_OFF_FLAGS, 8'h07);
        s0 = cnt;
        wr(`TMR_OFF_CTRL_B, 8'hC0);
        check(33'({pin_a, pin_b, fl_a, fl_b}), 33'hC);
        check(33'(cnt), 33'(s0));
        wr(`TMR_OFF_CTRL_A, 8'h60);
        wr(`TMR_OFF_CTRL_B, 8'h40);
        check(33'({pin_a, pin_b}), 33'h2);
        wr(`TMR_OFF_CTRL_A, 8'h33);
        wr(`TMR_OFF_CTRL_B, 8'h40);
        check(33'(pin_b), 33'h0);
        // Normal mode, channel B set, clear, toggle twice on match
        wr(`TMR_OFF_CTRL_A, 8'h00);
        wr(`TMR_OFF_CMP_B, 8'h10);
        wr(`TMR_OFF_CTRL_B, 8'h01);
        eb = 1'b0;
        for (int c = 0; c < 4; c++) begin
            logic [1:0] m;
            m = (c < 2) ? 2'(3 - c) : 2'd1;
            eb = m[1] ? m[0] : !eb;
            wr(`TMR_OFF_CTRL_A, {2'b00, m, 4'h0});
            wait_cnt(8'h08);
            wait_cnt(8'h14);
            check(33'({pin_b, fl_b}), 33'({eb, 1'b1}));
        end
        // Fast PWM with TOP from compare A equal to compare B
        wr(`TMR_OFF_CMP_A, 8'hA0);
        wr(`TMR_OFF_CMP_B, 8'hA0);
        wr(`TMR_OFF_CTRL_A, 8'h23);
        wr(`TMR_OFF_CTRL_B, 8'h09);
        wr(`TMR_OFF_FLAGS, 8'h07);
        wait_cnt(8'hA0);
        wait_cnt(8'h50);
        check(33'({pin_b, fl_ov}), 33'h3);
        // Fast PWM then phase correct, both polarities: same levels at 0x20 and 0x80
        wr(`TMR_OFF_CMP_B, 8'h40);
        wr(`TMR_OFF_CTRL_B, 8'h01);
        for (int m = 3; m >= 1; m -= 2) begin
            for (int c = 2; c <= 3; c++) begin
                wr(`TMR_OFF_CTRL_A, 8'(c * 16 + m));
                wait_cnt(8'hFF);
                wait_cnt(8'h20);
                check(33'(pin_b), 33'(c == 2));
                wait_cnt(8'h80);
                check(33'(pin_b), 33'(c == 3));
            end
        end
        // Stop and each prescaled clock source over a window of ten ticks; stop shows none
        wr(`TMR_OFF_CTRL_A, 8'h00);
        for (int i = 0; i <= 5; i++) begin
            wr(`TMR_OFF_CTRL_B, 8'(i));
            s0 = cnt;
            repeat (10 * divs[i]) @(posedge i_core_clk);
            check(33'(cnt), 33'(8'(s0 + ((i == 0) ? 8'd0 : 8'd10))));
        end
        // External count pin: eleven transitions give six of the selected edge
        for (int e = 6; e <= 7; e++) begin
            i_external_count_input <= (e == 6);
            repeat (6) @(posedge i_core_clk);
            wr(`TMR_OFF_CTRL_B, 8'(e));
            s0 = cnt;
            repeat (11) begin
                i_external_count_input <= !i_external_count_input;
                repeat (4 + $urandom % 8) @(posedge i_core_clk);
            end
            repeat (6) @(posedge i_core_clk);
            check(33'(cnt), 33'(8'(s0 + 8'd6)));
        end
        wrap_up();
    end
endmodule
`default_nettype wire
